//--- pkg/i2c_tgt_pkg.sv
/*
  Shared types and constants for the I2C target transmit block.
  Assumes one core clock plus a DMA-side link clock for transmit bytes.
*/
package i2c_tgt_pkg;
  // Command codes as reported in the pending-command field
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_ACK = 4'h1;
  localparam logic [3:0] CMD_STOP = 4'h2;
  localparam logic [3:0] CMD_RESET = 4'h3;
  localparam logic [3:0] CMD_CLR_TX = 4'h4;
  localparam logic [3:0] CMD_CLR_RX = 4'h5;
  // Event vector bit positions
  localparam int EV_XFER_DONE = 0;
  localparam int EV_TX_EMPTY = 1;
  localparam int EV_RX_FULL = 2;
  localparam int EV_DATA_NACK = 3;
  localparam int EV_DATA_ACK = 4;
  localparam int EV_COUNT_ZERO = 5;
  localparam int EV_ADDRESSED = 6;
  localparam int EV_BUS_ERR = 7;
  localparam logic [7:0] TEN_BIT_HDR = 8'hF0; // Upper five bits 11110
  localparam logic [7:0] GEN_CALL = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_DONE = 4'h8;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_ADDR = 4'h1, S_ADDR2 = 4'h2, S_AWAIT = 4'h3,
    S_ACKO = 4'h4, S_TXHOLD = 4'h5, S_TXBITS = 4'h6, S_TXACK = 4'h7,
    S_TXNEXT = 4'h8, S_RXBITS = 4'h9, S_RXHOLD = 4'hA, S_RELEASE = 4'hB
  } state_t;

  typedef struct packed {
    logic enable;
    logic autoCount;
    logic addrAck;
    logic gcEnable;
    logic priEnable;
    logic pri10b;
    logic [9:0] priAddr;
    logic secEnable;
    logic sec10b;
    logic [9:0] secAddr;
    logic [3:0] filterLength;
  } config_t;

  typedef struct packed {
    logic secMatch;
    logic priMatch;
    logic gcMatch;
    logic readDir;
    logic addrMatch;
    logic rptStart;
    logic startSeen;
    logic dataNack;
    logic dataAck;
    logic lastAck;
    logic [3:0] curCmd;
    logic sclHold;
    logic active;
    logic rxFull;
    logic txEmpty;
    logic xferDone;
    logic busErr;
  } status_t;
endpackage : i2c_tgt_pkg

//--- rtl/i2c_target_tx.sv
/*
  I2C target controller: slave-transmit path, receive holding byte,
  event sources and SDA/SCL glitch filters.
  Assumes open-drain pads resolved outside; transmit bytes arrive from a
  DMA engine on its own clock, everything else on core_clk.
*/
`timescale 1ns/1ps
// How it works
// RULE_01: Read transfer: start, read address, device acks, sends bytes, master nacks then stops.
// RULE_02: Ten-bit read: write header plus second byte, repeated start, header with read.
// RULE_03: Filtered start is flagged, address byte captured, compared, addressed event raised.
// RULE_04: Matching address acked automatically if enabled, else waits for ACK or STOP command.
// RULE_05: Mismatching address releases the bus; only the start flag shows it.
// RULE_06: After a read address ack, SCL is held low until a byte arrives.
// RULE_07: An arriving byte lands in the holder, moves to the shifter in the hold state, and the holder empties.
// RULE_08: Each sent byte steps the counter; then master ack is sampled and reported.
// RULE_09: Master ack waits for next byte; master nack releases both lines.
// RULE_10: STOP command during a byte executes only once that byte completes.
// RULE_11: Software preloads 0xFF before a short read frame so the master can stop.
// RULE_12: Repeated start with match flags it; count kept or cleared per countdown mode.
// RULE_13: Eight separate event outputs are provided for interrupt use.
// RULE_14: Transfer-complete sets on stop after addressing; cleared by status read or byte write.
// RULE_15: Transmit-empty is high whenever the holding register has no valid byte.
// RULE_16: Receive-full sets when a byte is loaded; cleared by receive read.
// RULE_17: Master nack after a data byte raises data-nack; status read clears.
// RULE_18: Master ack after a data byte raises data-ack; status read clears.
// RULE_19: Count-zero event is high whenever the counter holds zero.
// RULE_20: Addressed event on any configured or general-call match; status read clears.
// RULE_21: Bus error on misplaced start or stop or SDA readback mismatch while sending.
// RULE_22: Each line is synchronised and filtered; level must hold filter-length cycles.
// RULE_23: Pending-command field shows the executing command code, zero when done.
// RULE_24: Filter length is a live setting; a change also applies to an edge already being counted.
module i2c_target_tx
  import i2c_tgt_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic dmaClk,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOeN,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire config_t cfg,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  input wire logic statusRead,
  input wire logic rxRead,
  output logic [7:0] rxData,
  input wire logic countWrite,
  input wire logic [7:0] countValue,
  output logic [7:0] count,
  input wire logic cmdValid,
  input wire logic [3:0] cmdCode,
  output status_t status,
  output logic [7:0] events
);

  // DMA-side state: byte holder and request toggle
  typedef struct packed {
    logic [7:0] hold;
    logic reqT;
    logic ackS1;
    logic ackS2;
    logic ready;
  } link_t;

  typedef struct packed {
    state_t st;
    state_t ackNext;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] filt;
    logic [1:0] filtPrev;
    logic [1:0][3:0] fcnt;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] rxByte;
    logic [7:0] txByte;
    logic txFull;
    logic [7:0] count;
    status_t stat;
    logic addrEvt;
    logic [7:0] events;
    logic sdaOeN;
    logic sclOeN;
    logic zero;
    logic stopPend;
    logic tenHdr;
    logic dataSeen;
    logic wasAddr; // Addressed since the last stop; survives a nack release
    logic reqS1;
    logic reqS2;
    logic ackT;
  } core_t;

  link_t l_q, l_d;
  core_t q, d;

  // Seven-bit own-address compare
  function automatic logic hit7(input logic [7:0] b, input logic [9:0] a, input logic t10, input logic en);
    return en && !t10 && (b[7:1] == a[6:0]);
  endfunction : hit7

  // Ten-bit header compare, R/W bit excluded
  function automatic logic hdr10(input logic [7:0] b, input logic [9:0] a, input logic t10, input logic en);
    return en && t10 && (b[7:3] == TEN_BIT_HDR[7:3]) && (b[2:1] == a[9:8]);
  endfunction : hdr10

  // Link domain: accept a byte, raise toggle, wait for the echo
  always_comb begin
    l_d = l_q;
    l_d.ackS1 = q.ackT;
    l_d.ackS2 = l_q.ackS1;
    if (txValid && l_q.ready) begin
      l_d.hold = txData;
      l_d.reqT = !l_q.reqT;
    end
    // Ready only once the core echoed the last toggle
    l_d.ready = (l_d.reqT == l_d.ackS2);
  end

  always_ff @(posedge dmaClk or negedge resetn) begin
    if (!resetn) begin
      l_q <= '{hold: 8'h00, reqT: 1'b0, ackS1: 1'b0, ackS2: 1'b0, ready: 1'b1};
    end else begin
      l_q <= l_d;
    end
  end

  // Bus conditions seen on the filtered lines
  logic sclF, sdaF, sclRise, sclFall, startDet, stopDet, arrive, midByte;
  logic [7:0] b;
  logic tenRead, priHit, secHit, gcHit, anyHit;
  assign sclF = q.filt[0];
  assign sdaF = q.filt[1];
  assign sclRise = sclF && !q.filtPrev[0];
  assign sclFall = !sclF && q.filtPrev[0];
  assign startDet = sclF && q.filtPrev[0] && !sdaF && q.filtPrev[1];
  assign stopDet = sclF && q.filtPrev[0] && sdaF && !q.filtPrev[1];
  assign arrive = (q.reqS2 != q.ackT);
  // First rise of a byte may still turn into a start or stop, so it is not an error
  assign midByte = (q.bitCnt > 4'h1) && (q.st inside {S_ADDR, S_ADDR2, S_TXBITS, S_RXBITS});
  assign b = {q.shift[6:0], sdaF};
  assign tenRead = q.tenHdr && !q.dataSeen && b[0];
  assign priHit = hit7(b, cfg.priAddr, cfg.pri10b, cfg.priEnable)
    || (tenRead && hdr10(b, cfg.priAddr, cfg.pri10b, cfg.priEnable));
  assign secHit = hit7(b, cfg.secAddr, cfg.sec10b, cfg.secEnable)
    || (tenRead && hdr10(b, cfg.secAddr, cfg.sec10b, cfg.secEnable));
  assign gcHit = cfg.gcEnable && (b == GEN_CALL);
  assign anyHit = priHit || secHit || gcHit;

  // Main next-state process
  always_comb begin
    d = q;
    // Two-flop synchronisers, then hold-time filters
    d.sync1 = {sdaIn, sclIn};
    d.sync2 = q.sync1;
    d.filtPrev = q.filt;
    for (int i = 0; i < 2; i++) begin
      if (q.sync2[i] == q.filt[i]) begin
        d.fcnt[i] = 4'h0;
      end else if ((q.fcnt[i] + 4'h1) >= cfg.filterLength) begin
        d.filt[i] = q.sync2[i]; // RULE_22 RULE_24
        d.fcnt[i] = 4'h0;
      end else begin
        d.fcnt[i] = q.fcnt[i] + 4'h1;
      end
    end
    d.reqS1 = l_q.reqT;
    d.reqS2 = q.reqS1;
    // Status and receive reads clear first so a same-cycle set wins; the TX clear and reset commands still override a byte arrival
    if (statusRead) begin
      d.stat.busErr = 1'b0;
      d.stat.xferDone = 1'b0;
      d.stat.dataNack = 1'b0;
      d.stat.dataAck = 1'b0;
      d.stat.startSeen = 1'b0;
      d.stat.rptStart = 1'b0;
      d.addrEvt = 1'b0;
    end
    if (rxRead) begin
      d.stat.rxFull = 1'b0; // RULE_16
    end
    if (countWrite) begin
      d.count = countValue;
    end
    if (arrive) begin
      d.ackT = q.reqS2;
      d.txByte = l_q.hold;
      d.txFull = 1'b1; // RULE_15
      d.stat.xferDone = 1'b0; // RULE_14
    end
    d.stat.curCmd = CMD_NONE;
    if (cmdValid) begin
      d.stat.curCmd = cmdCode; // RULE_23
      case (cmdCode)
        CMD_ACK: begin
          if (q.st == S_AWAIT && !sclF) begin
            d.sdaOeN = 1'b0; // RULE_04
            d.sclOeN = 1'b1;
            d.st = S_ACKO;
          end
        end
        CMD_STOP: begin
          if (q.st inside {S_TXBITS, S_TXACK, S_TXNEXT, S_RXBITS}) begin
            d.stopPend = 1'b1; // RULE_10
          end else if (q.st != S_IDLE) begin
            d.st = S_RELEASE;
          end
        end
        CMD_RESET: begin
          d.st = S_IDLE;
          d.txFull = 1'b0;
          d.stat = '0;
          d.addrEvt = 1'b0;
          d.stopPend = 1'b0;
        end
        CMD_CLR_TX: d.txFull = 1'b0;
        CMD_CLR_RX: d.stat.rxFull = 1'b0;
        default: d.stat.curCmd = CMD_NONE;
      endcase
    end
    // Transfer sequencer
    case (q.st)
      S_IDLE, S_RELEASE: ;
      S_ADDR, S_ADDR2: begin
        if (sclRise) begin
          d.shift = b;
          d.bitCnt = q.bitCnt + 4'h1;
          if (q.bitCnt == BIT_LAST) begin
            d.bitCnt = 4'h0;
            d.ackNext = S_RELEASE;
            if (q.st == S_ADDR2) begin
              // Second byte of a ten-bit write address
              d.stat.priMatch = q.stat.priMatch && (b == cfg.priAddr[7:0]);
              d.stat.secMatch = q.stat.secMatch && (b == cfg.secAddr[7:0]);
              d.ackNext = (d.stat.priMatch || d.stat.secMatch) ? S_RXBITS : S_RELEASE;
            end else if (!b[0] && (hdr10(b, cfg.priAddr, cfg.pri10b, cfg.priEnable)
                || hdr10(b, cfg.secAddr, cfg.sec10b, cfg.secEnable))) begin
              // Header for write: acked silently, no report yet
              d.stat.priMatch = hdr10(b, cfg.priAddr, cfg.pri10b, cfg.priEnable);
              d.stat.secMatch = hdr10(b, cfg.secAddr, cfg.sec10b, cfg.secEnable);
              d.ackNext = S_ADDR2; // RULE_02
            end else if (anyHit) begin
              d.stat.priMatch = priHit;
              d.stat.secMatch = secHit;
              d.stat.gcMatch = gcHit;
              d.ackNext = b[0] ? S_TXHOLD : S_RXBITS; // RULE_01
            end
            if (d.ackNext inside {S_TXHOLD, S_RXBITS}) begin
              d.stat.addrMatch = 1'b1; // RULE_03 RULE_20
              d.addrEvt = 1'b1;
              d.wasAddr = 1'b1;
              d.stat.readDir = b[0];
              d.dataSeen = 1'b0;
              if (q.stat.rptStart && !cfg.autoCount) begin
                d.count = COUNT_RESET; // RULE_12
              end
              d.st = cfg.addrAck ? S_ACKO : S_AWAIT; // RULE_04
            end else if (d.ackNext == S_ADDR2) begin
              d.tenHdr = 1'b1;
              d.st = S_ACKO;
            end else begin
              d.st = S_RELEASE; // RULE_05
            end
          end
        end
      end
      S_AWAIT: d.sclOeN = sclF; // Stretch once SCL is low
      S_ACKO: begin
        if (sclFall) begin
          if (q.sdaOeN) begin
            d.sdaOeN = 1'b0;
          end else begin
            d.sdaOeN = 1'b1;
            d.st = q.ackNext;
          end
        end
      end
      S_TXHOLD: begin
        if (q.stopPend) begin
          d.st = S_RELEASE;
        end else if (q.txFull) begin
          d.shift = q.txByte; // RULE_07
          d.txFull = 1'b0;
          d.sdaOeN = q.txByte[7];
          d.sclOeN = 1'b1;
          d.bitCnt = 4'h0;
          d.count = cfg.autoCount ? q.count - 8'h01 : q.count + 8'h01; // RULE_08
          d.st = S_TXBITS;
        end else begin
          d.sclOeN = 1'b0; // RULE_06
        end
      end
      S_TXBITS: begin
        if (sclRise) begin
          d.bitCnt = q.bitCnt + 4'h1;
          if (sdaF != q.shift[7]) begin
            d.stat.busErr = 1'b1; // RULE_21
          end
        end else if (sclFall) begin
          if (q.bitCnt == BIT_DONE) begin
            d.sdaOeN = 1'b1;
            d.st = S_TXACK;
          end else begin
            d.shift = {q.shift[6:0], 1'b0};
            d.sdaOeN = q.shift[6];
          end
        end
      end
      S_TXACK: begin
        if (sclRise) begin
          d.stat.lastAck = sdaF; // RULE_08
          if (sdaF) begin
            d.stat.dataNack = 1'b1; // RULE_17
            d.st = S_RELEASE; // RULE_09
          end else begin
            d.stat.dataAck = 1'b1; // RULE_18
            d.st = S_TXNEXT;
          end
        end
      end
      S_TXNEXT: begin
        if (sclFall) begin
          d.st = q.stopPend ? S_RELEASE : S_TXHOLD; // RULE_09 RULE_10
        end
      end
      S_RXBITS: begin
        if (sclRise) begin
          d.shift = b;
          d.bitCnt = q.bitCnt + 4'h1;
          if (q.bitCnt == BIT_LAST) begin
            d.dataSeen = 1'b1;
            d.bitCnt = 4'h0;
            d.ackNext = S_RXBITS;
            if (q.stopPend) begin
              d.st = S_RELEASE; // RULE_10
            end else if (q.stat.rxFull) begin
              d.st = S_RXHOLD;
            end else begin
              d.rxByte = b;
              d.stat.rxFull = 1'b1; // RULE_16
              d.count = cfg.autoCount ? q.count - 8'h01 : q.count + 8'h01;
              d.st = S_ACKO;
            end
          end
        end
      end
      S_RXHOLD: begin
        d.sclOeN = sclF;
        if (!q.stat.rxFull && !sclF) begin
          d.rxByte = q.shift;
          d.stat.rxFull = 1'b1;
          d.count = cfg.autoCount ? q.count - 8'h01 : q.count + 8'h01;
          d.sdaOeN = 1'b0;
          d.sclOeN = 1'b1;
          d.st = S_ACKO;
        end
      end
      default: d.st = S_IDLE;
    endcase
    // Start and stop take over from any state
    if (startDet || stopDet) begin
      if (midByte) begin
        d.stat.busErr = 1'b1; // RULE_21
      end
      d.sdaOeN = 1'b1;
      d.sclOeN = 1'b1;
      d.bitCnt = 4'h0;
      d.stopPend = 1'b0;
    end
    if (startDet) begin
      if (q.st == S_IDLE) begin
        d.stat.startSeen = 1'b1; // RULE_03
        d.tenHdr = 1'b0;
      end else begin
        d.stat.rptStart = 1'b1; // RULE_12
      end
      d.stat.active = 1'b1;
      d.stat.addrMatch = 1'b0;
      d.st = S_ADDR;
    end else if (stopDet) begin
      if (q.wasAddr) begin
        d.stat.xferDone = 1'b1; // RULE_14
      end
      d.st = S_IDLE;
    end
    // Leaving the transfer frees the bus and drops the match
    if (d.st inside {S_IDLE, S_RELEASE}) begin
      d.sdaOeN = 1'b1;
      d.sclOeN = 1'b1;
      d.stopPend = 1'b0;
      d.stat.addrMatch = 1'b0;
      if (!startDet) begin
        d.stat.active = 1'b0;
      end
      if (d.st == S_IDLE) begin
        d.wasAddr = 1'b0;
      end
    end
    if (!cfg.enable) begin
      d.st = S_IDLE;
      d.sdaOeN = 1'b1;
      d.sclOeN = 1'b1;
      d.stat.active = 1'b0;
      d.stat.addrMatch = 1'b0;
      d.wasAddr = 1'b0;
    end
    if (d.stopPend) begin
      d.stat.curCmd = CMD_STOP;
    end
    d.stat.sclHold = !d.sclOeN; // RULE_06
    d.stat.txEmpty = !d.txFull; // RULE_15
    // Eight event sources, each a registered level
    d.events[EV_XFER_DONE] = d.stat.xferDone; // RULE_13
    d.events[EV_TX_EMPTY] = !d.txFull;
    d.events[EV_RX_FULL] = d.stat.rxFull;
    d.events[EV_DATA_NACK] = d.stat.dataNack;
    d.events[EV_DATA_ACK] = d.stat.dataAck;
    d.events[EV_COUNT_ZERO] = (d.count == 8'h00); // RULE_19
    d.events[EV_ADDRESSED] = d.addrEvt;
    d.events[EV_BUS_ERR] = d.stat.busErr;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.st <= S_IDLE;
      q.ackNext <= S_IDLE;
      q.sync1 <= 2'h3;
      q.sync2 <= 2'h3;
      q.filt <= 2'h3;
      q.filtPrev <= 2'h3;
      q.sdaOeN <= 1'b1;
      q.sclOeN <= 1'b1;
      q.stat.txEmpty <= 1'b1;
      q.events <= 8'h22; // Empty holder, zero count
    end else begin
      q <= d;
    end
  end

  assign sclOut = q.zero;
  assign sdaOut = q.zero;
  assign sclOeN = q.sclOeN;
  assign sdaOeN = q.sdaOeN;
  assign txReady = l_q.ready;
  assign rxData = q.rxByte;
  assign count = q.count;
  assign status = q.stat;
  assign events = q.events;

  // Checks on the sequencer
  count_zero_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_19
    events[EV_COUNT_ZERO] == (count == 8'h00)) else $error("count-zero event wrong");
  start_flag_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_03
    $rose(q.stat.startSeen) |-> q.st == S_ADDR) else $error("start flag without address phase");
  nack_release_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_09
    $rose(q.stat.dataNack) |-> q.st == S_RELEASE && sdaOeN && sclOeN) else $error("bus kept after nack");
  ack_wait_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_18
    $rose(q.stat.dataAck) |-> q.st == S_TXNEXT && !q.stat.lastAck) else $error("ack not followed by wait");
  hold_stretch_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_06
    (q.st == S_TXHOLD && !q.txFull && !q.stopPend && cfg.enable && !startDet && !stopDet && !cmdValid)
    |=> !sclOeN && status.sclHold) else $error("no stretch while waiting for byte");
  tx_load_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_07
    (q.st == S_TXHOLD && q.txFull && !q.stopPend && cfg.enable && !startDet && !stopDet && !cmdValid
    && !arrive && !countWrite) |=> q.st == S_TXBITS && status.txEmpty
    && count == ($past(cfg.autoCount) ? $past(count) - 8'h01 : $past(count) + 8'h01))
    else $error("byte not moved to shifter");
  done_flag_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_14
    (stopDet && q.wasAddr) |=> status.xferDone && events[EV_XFER_DONE]) else $error("no completion");
  stop_pend_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_10
    q.stopPend |-> q.st inside {S_TXBITS, S_TXACK, S_TXNEXT, S_RXBITS}) else $error("stop pending idle");
  filt_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_22
    $changed(q.filt[1]) |-> $past(q.sync2[1]) == q.filt[1]) else $error("filter output unsupported");
  nomatch_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_05
    (q.st == S_RELEASE) |-> sdaOeN && sclOeN && !status.addrMatch) else $error("bus held after release");

endmodule : i2c_target_tx

//--- testbench/i2c_master_model.sv
/*
  Behavioural I2C bus master that reads from the target.
  Assumes the bench resolves both open-drain lines with pull-ups.
*/
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic core_clk,
  input wire logic sclLine,
  input wire logic sdaLine,
  output logic sclDrv,
  output logic sdaDrv
);
  logic clash = 1'b0;
  // Both lines released at power-up
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  // Wait n core cycles, then step off the edge
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : hold
  // Release SCL; a stretching target keeps it low, bounded wait
  task automatic sclRise();
    int t;
    sclDrv = 1'b1;
    t = 0;
    while (!sclLine && t < 20000) begin
      hold(1);
      t++;
    end
    hold(20);
  endtask : sclRise
  task automatic putBit(input logic b);
    sdaDrv = b;
    hold(10);
    sclRise();
    sclDrv = 1'b0;
    hold(10);
  endtask : putBit
  // Clash pulls SDA low against the target's released bits
  task automatic getBit(output logic b);
    sdaDrv = ~clash;
    hold(10);
    sclRise();
    b = sdaLine;
    sclDrv = 1'b0;
    hold(10);
  endtask : getBit
  // Short low pulse on SDA while SCL idles high
  task automatic glitch(input int n);
    sdaDrv = 1'b0;
    hold(n);
    sdaDrv = 1'b1;
    hold(20);
  endtask : glitch
  // Start, or repeated start from a low clock
  task automatic startCond();
    sdaDrv = 1'b1;
    hold(10);
    sclRise();
    sdaDrv = 1'b0;
    hold(20);
    sclDrv = 1'b0;
    hold(10);
  endtask : startCond
  task automatic stopCond();
    sdaDrv = 1'b0;
    hold(10);
    sclRise();
    sdaDrv = 1'b1;
    hold(40);
  endtask : stopCond
  task automatic writeByte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) putBit(v[i]);
    getBit(ack);
  endtask : writeByte
  // Last byte of a read is answered with NACK
  task automatic readByte(input logic nack, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) getBit(v[i]);
    putBit(nack);
  endtask : readByte
endmodule : i2c_master_model

//--- testbench/i2c_target_transmit_irq_filter_tb.sv
/*
  Self-checking bench for the I2C target transmit block.
  Assumes the master model file is compiled first; pull-ups on both lines.
*/
`timescale 1ns/1ps
module i2c_target_transmit_irq_filter_tb
  import i2c_tgt_pkg::*;
;
  logic core_clk = 1'b0;
  logic dmaClk = 1'b0;
  logic resetn, sclOut, sclOeN, sdaOut, sdaOeN, txValid, txReady;
  logic statusRead, rxRead, countWrite, cmdValid, sclDrv, sdaDrv, ack;
  logic [7:0] txData, rxData, countValue, count, events, got;
  logic [3:0] cmdCode;
  config_t cfg;
  status_t status;
  int n_fail = 0;
  int compares = 0;
  // Wired-AND of open-drain parties
  wire sclIn = sclDrv & (sclOeN | sclOut);
  wire sdaIn = sdaDrv & (sdaOeN | sdaOut);

  initial forever #5 core_clk = ~core_clk;
  // Link clock offset so its edges never line up with the core
  initial begin
    #3;
    forever #7.5 dmaClk = ~dmaClk;
  end

  i2c_target_tx dut_u (.core_clk, .resetn, .dmaClk, .sclIn, .sclOut, .sclOeN, .sdaIn, .sdaOut,
    .sdaOeN, .cfg, .txValid, .txData, .txReady, .statusRead, .rxRead, .rxData, .countWrite,
    .countValue, .count, .cmdValid, .cmdCode, .status, .events);
  i2c_master_model mdl_u (.core_clk, .sclLine(sclIn), .sdaLine(sdaIn), .sclDrv, .sdaDrv);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  // Offer one byte, held until the edge after ready is seen
  task automatic pushByte(input logic [7:0] b);
    int t;
    @(posedge dmaClk);
    #1;
    txValid = 1'b1;
    txData = b;
    for (t = 0; !txReady && t < 100; t++) begin
      @(posedge dmaClk);
      #1;
    end
    @(posedge dmaClk);
    #1;
    txValid = 1'b0;
    cyc(12);
  endtask : pushByte

  // Watchdog, well beyond the expected run
  initial begin
    #400000;
    n_fail++;
    test_done();
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    {txValid, statusRead, rxRead, countWrite, cmdValid} = '0;
    txData = 8'h00;
    countValue = 8'h00;
    cmdCode = CMD_NONE;
    cfg = '0;
    {cfg.enable, cfg.autoCount, cfg.addrAck, cfg.priEnable, cfg.secEnable, cfg.sec10b} = 6'h3F;
    cfg.priAddr = 10'h02A;
    cfg.secAddr = 10'h2B5;
    cfg.filterLength = 4'h4;
    repeat (5) @(posedge core_clk);
    #1 resetn = 1'b1;
    cyc(10);
    check(events, 8'h22);
    check({sclOeN, sdaOeN, txReady, status.txEmpty}, 8'h0F);
    mdl_u.glitch(2);
    check(status.startSeen, 8'h00);
    // Seven-bit read of two bytes, countdown from 2
    countValue = 8'h02;
    pulse(countWrite);
    mdl_u.startCond();
    check(status.startSeen, 8'h01);
    mdl_u.writeByte({7'h2A, 1'b1}, ack);
    check(ack, 8'h00);
    check({status.addrMatch, status.readDir, events[6]}, 8'h07);
    cyc(20);
    check({status.sclHold, sclIn}, 8'h02);
    pushByte(8'hA5);
    check(events[1], 8'h01);
    check(count, 8'h01);
    mdl_u.readByte(1'b0, got);
    check(got, 8'hA5);
    check({events[4], status.lastAck}, 8'h02);
    pushByte(8'h3C);
    check(events[5], 8'h01);
    check(count, 8'h00);
    mdl_u.readByte(1'b1, got);
    cyc(5);
    check(got, 8'h3C);
    check({events[3], sclOeN, sdaOeN}, 8'h07);
    mdl_u.stopCond();
    check(events[0], 8'h01);
    pulse(statusRead);
    check({events[0], events[3], events[4], events[6]}, 8'h00);
    // Foreign address is left unanswered
    mdl_u.startCond();
    mdl_u.writeByte({7'h11, 1'b1}, ack);
    check(ack, 8'h01);
    mdl_u.stopCond();
    check({status.startSeen, status.addrMatch, events[6], events[0]}, 8'h08);
    pulse(statusRead);
    // Ten-bit read through repeated start, count kept
    countValue = 8'h03;
    pulse(countWrite);
    mdl_u.startCond();
    mdl_u.writeByte(8'hF4, ack);
    check(ack, 8'h00);
    mdl_u.writeByte(8'hB5, ack);
    check(ack, 8'h00);
    mdl_u.startCond();
    mdl_u.writeByte(8'hF5, ack);
    check(ack, 8'h00);
    check({status.rptStart, status.secMatch, status.readDir}, 8'h07);
    check(count, 8'h03);
    pushByte(8'hFF);
    mdl_u.clash = 1'b1;
    mdl_u.readByte(1'b1, got);
    mdl_u.clash = 1'b0;
    check(events[7], 8'h01);
    check(count, 8'h02);
    mdl_u.stopCond();
    pulse(statusRead);
    // Idle byte parked, then thrown away by command
    pushByte(8'h5A);
    check(events[1], 8'h00);
    cmdCode = CMD_CLR_TX;
    pulse(cmdValid);
    check(status.curCmd, CMD_CLR_TX);
    cyc(3);
    check({status.curCmd, events[1]}, 8'h01);
    test_done();
  end
endmodule : i2c_target_transmit_irq_filter_tb
